/* hdl/mwd_defs.vh */
/*
 * constants for the masked write command decode: command codes on the
 * decoded command pins, mask bit positions and output layout.
 * assumes the includer uses the names below only as plain sized literals.
 */
`ifndef MWD_DEFS_VH
`define MWD_DEFS_VH

// decoded command codes on cmd_i
`define MWD_CMD_NOP 3'h0
`define MWD_ROW_ACTIVATE_CMD 3'h1
`define MWD_UNMASKED_WRITE_CMD 3'h2
`define MWD_DOUBLEBYTE_MASKED_WRITE_CMD 3'h3
`define MWD_SINGLEBYTE_MASKED_WRITE_CMD 3'h4
`define MWD_CMD_DESEL 3'h7

// pin widths
`define MWD_ADDR_W 12
`define MWD_BANK_W 4

// mask gathered on a ck rising edge: bit n of the rise vector
`define MWD_RB_A10 0
`define MWD_RB_A9 1
`define MWD_RB_BA0 2
`define MWD_RB_BA3 3
`define MWD_RB_BA2 4
`define MWD_RB_BA1 5
`define MWD_RB_A11 6
`define MWD_RB_A8 7

// mask layout: bit = burst * lanes + byte lane
`define MWD_LANES 4
`define MWD_BURSTS 8
`define MWD_MASK_W 32

// mask value meaning per bit
`define MWD_MASK_WRITE 1'b0
`define MWD_MASK_INHIBIT 1'b1

// one mask cycle kind given to the map
`define MWD_KIND_DBL 2'h0
`define MWD_KIND_SGL1 2'h1
`define MWD_KIND_SGL2 2'h2

`endif

/* hdl/mwd_mask_map.v */
/*
 * maps one mask command cycle (rising and complementary edge bits) onto
 * the 32 byte/burst mask bits of a burst of eight.
 * assumes rise_i/fall_i already gathered from the pins; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.vh"

module mwd_mask_map (
	input wire [7:0] rise_i,
	input wire [7:0] fall_i,
	input wire [1:0] kind_i,
	input wire x16_i,
	input wire mirror_i,
	output wire [`MWD_MASK_W-1:0] mask_o
);
	reg lo_en;
	reg hi_en;

	// lo_en selects lanes 0/2, hi_en lanes 1/3 for groups 0/1
	always @* begin
		lo_en = 1'b0;
		hi_en = 1'b0;
		case (kind_i)
			`MWD_KIND_DBL: begin
				lo_en = ~x16_i | ~mirror_i;
				hi_en = ~x16_i | mirror_i;
			end
			`MWD_KIND_SGL1: begin
				lo_en = ~(x16_i & mirror_i);
			end
			`MWD_KIND_SGL2: begin
				hi_en = ~(x16_i & ~mirror_i);
			end
			default: begin
				lo_en = 1'b0;
				hi_en = 1'b0;
			end
		endcase
	end

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_burst
			// bursts 0-3 from the ck edge, 4-7 from the ck# edge
			assign mask_o[b*4+0] = rise_i[b] & lo_en;
			assign mask_o[b*4+1] = rise_i[b] & hi_en;
			assign mask_o[b*4+2] = rise_i[b+4] & lo_en;
			assign mask_o[b*4+3] = rise_i[b+4] & hi_en;
			assign mask_o[(b+4)*4+0] = fall_i[b] & lo_en;
			assign mask_o[(b+4)*4+1] = fall_i[b] & hi_en;
			assign mask_o[(b+4)*4+2] = fall_i[b+4] & lo_en;
			assign mask_o[(b+4)*4+3] = fall_i[b+4] & hi_en;
		end
	endgenerate

endmodule // mwd_mask_map

`default_nettype wire

/* hdl/mwd_top.v */
/*
 * masked write command decode: samples the command clock and command and
 * address pins, recognises the three write variants, gathers mask cycles
 * and presents per-byte, per-burst mask and write enables for the burst.
 * assumes ck_i, cmd_i, addr_i, bank_i come from pins (asynchronous to mclk_i),
 * ck_i slow enough for at least two mclk samples per half period.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.vh"

module mwd_top (
	input wire mclk_i,
	input wire rst_n_i,
	input wire ck_i,
	input wire [2:0] cmd_i,
	input wire [`MWD_ADDR_W-1:0] addr_i,
	input wire [`MWD_BANK_W-1:0] bank_i,
	input wire x16_i,
	input wire mirror_i,
	output reg write_done_o,
	output reg [2:0] write_cmd_o,
	output reg [`MWD_ADDR_W-1:0] write_addr_o,
	output reg [`MWD_BANK_W-1:0] write_bank_o,
	output reg [`MWD_MASK_W-1:0] write_mask_flag_o,
	output reg [`MWD_MASK_W-1:0] byte_we_o,
	output reg cmd_gap_err_o
);
	localparam [5:0] S_IDLE = 6'b000001;
	localparam [5:0] S_CMDF = 6'b000010;
	localparam [5:0] S_M1R = 6'b000100;
	localparam [5:0] S_M1F = 6'b001000;
	localparam [5:0] S_M2R = 6'b010000;
	localparam [5:0] S_M2F = 6'b100000;

	// gathers the eight rising-edge mask pins into their bit order
	function [7:0] rise_gather;
		input [`MWD_ADDR_W-1:0] a;
		input [`MWD_BANK_W-1:0] ba;
		begin
			rise_gather = 8'h00;
			rise_gather[`MWD_RB_A10] = a[10];
			rise_gather[`MWD_RB_A9] = a[9];
			rise_gather[`MWD_RB_BA0] = ba[0];
			rise_gather[`MWD_RB_BA3] = ba[3];
			rise_gather[`MWD_RB_BA2] = ba[2];
			rise_gather[`MWD_RB_BA1] = ba[1];
			rise_gather[`MWD_RB_A11] = a[11];
			rise_gather[`MWD_RB_A8] = a[8];
		end
	endfunction

	// true for commands allowed on the mask cycles of a write
	function is_idle_cmd;
		input [2:0] c;
		begin
			is_idle_cmd = (c == `MWD_CMD_NOP) || (c == `MWD_CMD_DESEL);
		end
	endfunction

	// two-flop synchronisers; ck gets a third flop for edge finding
	reg ck_m_r;
	reg ck_s_r;
	reg ck_d_r;
	reg [2:0] cmd_m_r;
	reg [2:0] cmd_s_r;
	reg [`MWD_ADDR_W-1:0] addr_m_r;
	reg [`MWD_ADDR_W-1:0] addr_s_r;
	reg [`MWD_BANK_W-1:0] bank_m_r;
	reg [`MWD_BANK_W-1:0] bank_s_r;

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ck_m_r <= 1'b0;
			ck_s_r <= 1'b0;
			ck_d_r <= 1'b0;
			cmd_m_r <= `MWD_CMD_NOP;
			cmd_s_r <= `MWD_CMD_NOP;
			addr_m_r <= {`MWD_ADDR_W{1'b0}};
			addr_s_r <= {`MWD_ADDR_W{1'b0}};
			bank_m_r <= {`MWD_BANK_W{1'b0}};
			bank_s_r <= {`MWD_BANK_W{1'b0}};
		end else begin
			ck_m_r <= ck_i;
			ck_s_r <= ck_m_r;
			ck_d_r <= ck_s_r;
			cmd_m_r <= cmd_i;
			cmd_s_r <= cmd_m_r;
			addr_m_r <= addr_i;
			addr_s_r <= addr_m_r;
			bank_m_r <= bank_i;
			bank_s_r <= bank_m_r;
		end
	end

	// pins were sampled alongside ck, so they are aligned with its edge
	wire ck_rise = ck_s_r & ~ck_d_r;
	wire ck_fall = ~ck_s_r & ck_d_r;
	wire [7:0] fall_bits = addr_s_r[7:0];

	reg [5:0] state_r;
	reg [5:0] state_nxt;
	reg [2:0] kind_r;
	reg [7:0] rise_r;
	reg [`MWD_ADDR_W-1:0] wa_r;
	reg [`MWD_BANK_W-1:0] wb_r;
	reg [`MWD_MASK_W-1:0] acc_r;
	reg [1:0] map_kind;
	reg finish;

	wire [`MWD_MASK_W-1:0] cyc_mask;

	// mask cycle decode never looks at error detect return setting
	mwd_mask_map u_map (
		.rise_i(rise_r),
		.fall_i(fall_bits),
		.kind_i(map_kind),
		.x16_i(x16_i),
		.mirror_i(mirror_i),
		.mask_o(cyc_mask)
	);

	always @* begin
		state_nxt = state_r;
		finish = 1'b0;
		map_kind = `MWD_KIND_DBL;
		case (state_r)
			S_IDLE: begin
				// row activate and other commands belong to the row logic
				if (ck_rise && (cmd_s_r == `MWD_UNMASKED_WRITE_CMD ||
					cmd_s_r == `MWD_DOUBLEBYTE_MASKED_WRITE_CMD ||
					cmd_s_r == `MWD_SINGLEBYTE_MASKED_WRITE_CMD)) begin
					state_nxt = S_CMDF;
				end
			end
			S_CMDF: begin
				if (ck_fall) begin
					if (kind_r == `MWD_UNMASKED_WRITE_CMD) begin
						state_nxt = S_IDLE;
						finish = 1'b1;
					end else begin
						state_nxt = S_M1R;
					end
				end
			end
			S_M1R: begin
				if (ck_rise) begin
					state_nxt = S_M1F;
				end
			end
			S_M1F: begin
				map_kind = (kind_r == `MWD_SINGLEBYTE_MASKED_WRITE_CMD) ? `MWD_KIND_SGL1 : `MWD_KIND_DBL;
				if (ck_fall) begin
					if (kind_r == `MWD_SINGLEBYTE_MASKED_WRITE_CMD) begin
						state_nxt = S_M2R;
					end else begin
						state_nxt = S_IDLE;
						finish = 1'b1;
					end
				end
			end
			S_M2R: begin
				map_kind = `MWD_KIND_SGL2;
				if (ck_rise) begin
					state_nxt = S_M2F;
				end
			end
			S_M2F: begin
				map_kind = `MWD_KIND_SGL2;
				if (ck_fall) begin
					state_nxt = S_IDLE;
					finish = 1'b1;
				end
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	wire in_mask_rise = ck_rise && (state_r == S_M1R || state_r == S_M2R);
	wire mask_fall = ck_fall && (state_r == S_M1F || state_r == S_M2F);
	// accumulated mask including the cycle being closed this edge
	wire [`MWD_MASK_W-1:0] acc_now = mask_fall ? (acc_r | cyc_mask) : acc_r;

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= S_IDLE;
			kind_r <= `MWD_CMD_NOP;
			rise_r <= 8'h00;
			wa_r <= {`MWD_ADDR_W{1'b0}};
			wb_r <= {`MWD_BANK_W{1'b0}};
			acc_r <= {`MWD_MASK_W{1'b0}};
		end else begin
			state_r <= state_nxt;
			if (state_r == S_IDLE && state_nxt == S_CMDF) begin
				kind_r <= cmd_s_r;
				wa_r <= addr_s_r;
				wb_r <= bank_s_r;
				acc_r <= {`MWD_MASK_W{`MWD_MASK_WRITE}};
			end else begin
				acc_r <= acc_now;
			end
			// mask bits share the address pins with the command
			if (in_mask_rise) begin
				rise_r <= rise_gather(addr_s_r, bank_s_r);
			end
		end
	end

	// mask cycles must carry nop or deselect; the burst is kept regardless
	wire gap_bad = in_mask_rise && !is_idle_cmd(cmd_s_r);

	always @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			write_done_o <= 1'b0;
			write_cmd_o <= `MWD_CMD_NOP;
			write_addr_o <= {`MWD_ADDR_W{1'b0}};
			write_bank_o <= {`MWD_BANK_W{1'b0}};
			write_mask_flag_o <= {`MWD_MASK_W{1'b0}};
			byte_we_o <= {`MWD_MASK_W{1'b0}};
			cmd_gap_err_o <= 1'b0;
		end else begin
			write_done_o <= finish;
			cmd_gap_err_o <= gap_bad;
			if (finish) begin
				write_cmd_o <= kind_r;
				write_addr_o <= wa_r;
				write_bank_o <= wb_r;
				write_mask_flag_o <= acc_now;
				byte_we_o <= ~acc_now;
			end
		end
	end

endmodule // mwd_top

`default_nettype wire

/* sim/mwd_top_chk.sv */
/* assertions on the masked write decode outputs.
   assumes binding onto mwd_top, one mclk_i domain. */
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.vh"
module mwd_chk (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ck_i,
	input wire logic x16_i,
	input wire logic mirror_i,
	input wire logic write_done_o,
	input wire logic [2:0] write_cmd_o,
	input wire logic [`MWD_MASK_W-1:0] write_mask_flag_o,
	input wire logic [`MWD_MASK_W-1:0] byte_we_o,
	input wire logic cmd_gap_err_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [31:0] m = write_mask_flag_o;
	chk_we_inverse: assert property (write_done_o |-> byte_we_o == ~m)
		else $error("write enables not mask inverse");
	chk_mask_stands: assert property (!write_done_o |-> $stable(m))
		else $error("mask moved without done");
	chk_done_pulse: assert property (write_done_o |=> !write_done_o)
		else $error("done longer than one cycle");
	chk_cmd_kind: assert property (write_done_o |-> write_cmd_o inside {`MWD_UNMASKED_WRITE_CMD,
		`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, `MWD_SINGLEBYTE_MASKED_WRITE_CMD})
		else $error("done for a non write");
	chk_plain_full: assert property (write_done_o && write_cmd_o == `MWD_UNMASKED_WRITE_CMD |-> m == 32'h0)
		else $error("plain write masked");
	chk_x16_lanes: assert property (write_done_o && x16_i |-> (m & (mirror_i ? 32'h55555555 : 32'haaaaaaaa)) == 32'h0)
		else $error("unused lane masked");
	chk_pair_lanes: assert property (write_done_o && write_cmd_o == `MWD_DOUBLEBYTE_MASKED_WRITE_CMD
		&& !x16_i |-> ((m & 32'h55555555) << 1) == (m & 32'haaaaaaaa))
		else $error("doublebyte pair split");
	chk_done_ck_low: assert property (write_done_o |-> !ck_i && !$past(ck_i, 2))
		else $error("done not after ck fall");
	chk_gap_pulse: assert property (cmd_gap_err_o |=> !cmd_gap_err_o)
		else $error("gap flag longer than one cycle");
endmodule // mwd_chk
bind mwd_top mwd_chk u_chk (
	.mclk_i(mclk_i),
	.rst_n_i(rst_n_i),
	.ck_i(ck_i),
	.x16_i(x16_i),
	.mirror_i(mirror_i),
	.write_done_o(write_done_o),
	.write_cmd_o(write_cmd_o),
	.write_mask_flag_o(write_mask_flag_o),
	.byte_we_o(byte_we_o),
	.cmd_gap_err_o(cmd_gap_err_o)
);
`default_nettype wire

/* sim/mwd_ctl_model.sv */
/* controller model: drives command clock, command and address pins.
   assumes mclk_i at 40 MHz; ck half period is four mclk cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.vh"
module mwd_ctl_model (
	input wire logic mclk_i,
	output logic ck_o,
	output logic [2:0] cmd_o,
	output logic [`MWD_ADDR_W-1:0] addr_o,
	output logic [`MWD_BANK_W-1:0] bank_o
);
	initial begin
		ck_o = 1'b0;
		cmd_o = `MWD_CMD_DESEL;
		addr_o = 12'h0;
		bank_o = 4'h0;
	end
	task automatic tick(input int t);
		repeat (t) @(posedge mclk_i);
	endtask
	// m holds {fall2, rise2, fall1, rise1}; ck stays low outside frames
	task automatic frame(input [2:0] c, input [2:0] g, input [11:0] a, input [3:0] ba, input [31:0] m, input int n);
		logic [7:0] r;
		for (int k = 0; k < n; k++) begin
			cmd_o <= k ? g : c;
			if (k == 0) begin
				addr_o <= a;
				bank_o <= ba;
			end else begin
				r = 8'(m >> (16 * k - 16));
				addr_o <= {r[6], r[0], r[1], r[7], ~addr_o[7:0]};
				bank_o <= {r[3], r[4], r[5], r[2]};
			end
			tick(2);
			ck_o <= 1'b1;
			tick(2);
			addr_o[7:0] <= k ? 8'(m >> (16 * k - 8)) : ~addr_o[7:0];
			tick(2);
			ck_o <= 1'b0;
			tick(2);
		end
	endtask
	// released pins invert so a stale value never looks valid
	task automatic rest;
		cmd_o <= `MWD_CMD_DESEL;
		addr_o <= ~addr_o;
		bank_o <= ~bank_o;
	endtask
endmodule // mwd_ctl_model
`default_nettype wire

/* sim/mwd_tb.sv */
/* self-checking bench for the masked write decode.
   assumes mwd_ctl_model on the pins and the checker bound to mwd_top. */
`timescale 1ns/1ps
`default_nettype none
`include "mwd_defs.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; $display("ERROR %s exp %h seen %h", n, e, s); end end
module testbench;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, x16_i = 1'b0, mirror_i = 1'b0;
	wire logic ck_i;
	wire logic [2:0] cmd_i;
	wire logic [11:0] addr_i;
	wire logic [3:0] bank_i;
	wire logic write_done_o, cmd_gap_err_o;
	wire logic [2:0] write_cmd_o;
	wire logic [11:0] write_addr_o;
	wire logic [3:0] write_bank_o;
	wire logic [31:0] write_mask_flag_o, byte_we_o;
	int error_cnt = 0, check_count = 0, dones = 0, gaps = 0;
	mwd_ctl_model ctl (.mclk_i(mclk_i), .ck_o(ck_i), .cmd_o(cmd_i), .addr_o(addr_i), .bank_o(bank_i));
	mwd_top dut (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ck_i(ck_i),
		.cmd_i(cmd_i),
		.addr_i(addr_i),
		.bank_i(bank_i),
		.x16_i(x16_i),
		.mirror_i(mirror_i),
		.write_done_o(write_done_o),
		.write_cmd_o(write_cmd_o),
		.write_addr_o(write_addr_o),
		.write_bank_o(write_bank_o),
		.write_mask_flag_o(write_mask_flag_o),
		.byte_we_o(byte_we_o),
		.cmd_gap_err_o(cmd_gap_err_o)
	);
	initial forever #12.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		dones <= dones + write_done_o;
		gaps <= gaps + cmd_gap_err_o;
	end
	function automatic [31:0] put(input [7:0] r, input [7:0] f, input [3:0] l0, input [3:0] l1);
		logic [3:0] lm;
		put = 32'h0;
		for (int i = 0; i < 8; i++) begin
			lm = i < 4 ? l0 : l1;
			for (int l = 0; l < 4; l++) if (lm[l]) begin
				put[i % 4 * 4 + l] = r[i];
				put[(4 + i % 4) * 4 + l] = f[i];
			end
		end
	endfunction
	function automatic [31:0] expm(input [2:0] c, input [31:0] m, input x, input mr);
		if (c == `MWD_DOUBLEBYTE_MASKED_WRITE_CMD)
			expm = put(m[7:0], m[15:8], x ? (mr ? 4'h2 : 4'h1) : 4'h3,
				x ? (mr ? 4'h8 : 4'h4) : 4'hc);
		else if (c == `MWD_SINGLEBYTE_MASKED_WRITE_CMD)
			expm = (x && mr ? 32'h0 : put(m[7:0], m[15:8], 4'h1, 4'h4))
				| (x && !mr ? 32'h0 : put(m[23:16], m[31:24], 4'h2, 4'h8));
		else
			expm = 32'h0;
	endfunction
	task automatic expect_w(input [2:0] c, input [11:0] a, input [3:0] ba, input [31:0] m);
		int i, d0;
		d0 = dones;
		for (i = 0; i < 200 && dones == d0; i++) @(negedge mclk_i);
		if (i == 200) begin error_cnt++; final_report; end
		`CHK("cmd", c, write_cmd_o)
		`CHK("addr", a, write_addr_o)
		`CHK("bank", ba, write_bank_o)
		`CHK("mask", m, write_mask_flag_o)
		`CHK("we", ~m, byte_we_o)
	endtask
	task automatic wr(input [2:0] c, input [11:0] a, input [3:0] ba, input [31:0] m, input x, input mr);
		int n;
		n = c == `MWD_SINGLEBYTE_MASKED_WRITE_CMD ? 3 : c == `MWD_DOUBLEBYTE_MASKED_WRITE_CMD ? 2 : 1;
		@(posedge mclk_i);
		x16_i <= x;
		mirror_i <= mr;
		fork
			begin ctl.frame(c, `MWD_CMD_NOP, a, ba, m, n); ctl.rest; end
			expect_w(c, a, ba, expm(c, m, x, mr));
		join
	endtask
	task t_plain;
		wr(`MWD_UNMASKED_WRITE_CMD, 12'h5a3, 4'h9, 32'hffffffff, 1'b0, 1'b0);
		$display("t_plain end");
	endtask
	// k = 3 runs x32 with mirroring, which must map as plain x32
	task t_dbl;
		for (int k = 0; k < 4; k++)
			wr(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, 12'h2c1, 4'h6, 32'h0000c35a,
				k == 1 || k == 2, k > 1);
		$display("t_dbl end");
	endtask
	task t_sgl;
		for (int k = 0; k < 4; k++)
			wr(`MWD_SINGLEBYTE_MASKED_WRITE_CMD, 12'h7e4, 4'hb, 32'h96e1a53c,
				k == 1 || k == 2, k > 1);
		$display("t_sgl end");
	endtask
	task t_gap;
		int d;
		@(posedge mclk_i);
		x16_i <= 1'b0;
		mirror_i <= 1'b0;
		d = dones;
		ctl.frame(`MWD_ROW_ACTIVATE_CMD, `MWD_CMD_NOP, 12'h100, 4'h6, 32'h0, 1);
		ctl.rest;
		repeat (12) @(posedge mclk_i);
		`CHK("row_done", d, dones)
		d = gaps;
		fork
			begin
				ctl.frame(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, `MWD_ROW_ACTIVATE_CMD, 12'h0f0, 4'h6, 32'h0000ff00, 2);
				ctl.rest;
			end
			expect_w(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, 12'h0f0, 4'h6,
				expm(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, 32'h0000ff00, 1'b0, 1'b0));
		join
		`CHK("gap_err", d + 1, gaps)
		$display("t_gap end");
	endtask
	task t_b2b;
		@(posedge mclk_i);
		fork
			begin
				ctl.frame(`MWD_SINGLEBYTE_MASKED_WRITE_CMD, `MWD_CMD_DESEL, 12'h3a5, 4'h2, 32'h01804020, 3);
				ctl.frame(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, `MWD_CMD_NOP, 12'h0c3, 4'ha, 32'h00008001, 2);
				ctl.rest;
			end
			begin
				expect_w(`MWD_SINGLEBYTE_MASKED_WRITE_CMD, 12'h3a5, 4'h2,
					expm(`MWD_SINGLEBYTE_MASKED_WRITE_CMD, 32'h01804020, 1'b0, 1'b0));
				expect_w(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, 12'h0c3, 4'ha,
					expm(`MWD_DOUBLEBYTE_MASKED_WRITE_CMD, 32'h00008001, 1'b0, 1'b0));
			end
		join
		$display("t_b2b end");
	endtask
	task final_report;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_plain;
		t_dbl;
		t_sgl;
		t_gap;
		t_b2b;
		final_report;
	end
endmodule // testbench
`default_nettype wire
